// ===== include/pogdr_pkg.sv
// shared constants and types for the pixel offset, gain and dummy-row block
// Summary of operation
// [RL1] The dark-level offset is a 14-bit two's complement value from +8191 down to -8192.
// [RL2] The output dark level is the fixed converter offset of 70 plus the signed offset.
// [RL3] The offset resets to 16323 (-61), low byte at address 100, upper six bits at 101.
// [RL4] A two-bit column gain select gives x1, x1.2, x1.4 or x1.6 and resets to 0.
// [RL5] A doubling bit multiplies the selected column gain by two and leaves the select alone.
// [RL6] An eight-bit ramp gain, reset 32, sets the conversion ramp slope, higher is more gain.
// [RL7] With the black column enable set the first 16 columns carry the black reference.
// [RL8] Each global transfer pulse inserts the programmed count of dummy rows into readout.
// [RL9] During each dummy row the pixel-valid and line-valid outputs stay low.
// [RL10] The receiver qualifies data only by the valid strobes and assumes no fixed row count.
// [RL11] The dummy row count resets to 0, so no dummy rows are inserted until programmed.
// [RL12] Software sets the integration sync bit whenever it programs a nonzero dummy count.
// [RL13] One unit of the dummy count is one full line-valid pulse period.
// [RL14] In dual exposure the dummy rows are inserted at both transfer pulse toggles.
// [RL15] The sum of converted code and offset saturates to the code range instead of wrapping.
package pogdr_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int OFFSET_W = 14;
  localparam int CODE_W = 12;
  localparam int COL_W = 11;
  localparam int SUM_W = 16;
  localparam logic [6:0] OFS_INTE_SYNC = 7'h29;
  localparam logic [6:0] OFS_OFFSET_LO = 7'h64;
  localparam logic [6:0] OFS_OFFSET_HI = 7'h65;
  localparam logic [6:0] OFS_AMP_GAIN = 7'h66;
  localparam logic [6:0] OFS_RAMP_GAIN = 7'h67;
  localparam logic [6:0] OFS_DUMMY = 7'h76;
  localparam logic [6:0] OFS_DBL_BLACK = 7'h79;
  localparam int INTE_SYNC_BIT = 2;
  localparam int AMP_DOUBLE_BIT = 0;
  localparam int BLACK_EN_BIT = 1;
  localparam logic [13:0] RST_OFFSET = 14'h3fc3;
  localparam logic [1:0] RST_AMP_GAIN = 2'h0;
  localparam logic [7:0] RST_RAMP_GAIN = 8'h20;
  localparam logic [7:0] RST_DUMMY = 8'h00;
  localparam logic RST_INTE_SYNC = 1'b0;
  localparam logic RST_AMP_DOUBLE = 1'b0;
  localparam logic RST_BLACK_EN = 1'b0;
  localparam logic signed [15:0] ADC_FIXED_OFFSET = 16'sh0046;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam logic [10:0] BLACK_COLS = 11'h010;
  localparam logic [5:0] GAIN_X10_0 = 6'h0a;
  localparam logic [5:0] GAIN_X10_1 = 6'h0c;
  localparam logic [5:0] GAIN_X10_2 = 6'h0e;
  localparam logic [5:0] GAIN_X10_3 = 6'h10;
  localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SPI_FRAME_END = 5'h10;

  typedef enum logic [2:0] {
    POGDR_IDLE = 3'b001,
    POGDR_ARMED = 3'b010,
    POGDR_DUMMY = 3'b100
  } pogdr_state_t;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic pixel_valid;
    logic [10:0] col;
    logic [11:0] code;
  } pogdr_pix_in_t;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic pixel_valid;
    logic [11:0] code;
  } pogdr_pix_out_t;

  typedef struct packed {
    logic inte_sync;
    logic [13:0] offset;
    logic [1:0] amp_gain;
    logic [7:0] ramp_gain;
    logic [7:0] dummy;
    logic amp_double;
    logic black_en;
  } pogdr_cfg_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } pogdr_wr_t;
endpackage

// ===== core/pogdr_cfg_port.sv
// serial configuration port, runs on the link clock
`timescale 1ns/1ps
module pogdr_cfg_port (
  input wire logic spi_clk,
  input wire logic reset,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  input wire pogdr_pkg::pogdr_cfg_t cfg,
  output pogdr_pkg::pogdr_wr_t wr_word,
  output logic wr_toggle
);
  logic clr;
  logic [4:0] cnt_q;
  logic [14:0] sh_q;
  logic [6:0] rd_sh_q;
  logic [15:0] full;
  logic [6:0] rd_addr;

  // cfg only changes after a write frame has ended, so it is stable here
  function automatic logic [7:0] read_mux(input logic [6:0] a, input pogdr_pkg::pogdr_cfg_t c);
    logic [7:0] v;
    v = 8'h00;
    if (a == pogdr_pkg::OFS_INTE_SYNC) begin
      v[pogdr_pkg::INTE_SYNC_BIT] = c.inte_sync;
    end else if (a == pogdr_pkg::OFS_OFFSET_LO) begin
      v = c.offset[7:0];
    end else if (a == pogdr_pkg::OFS_OFFSET_HI) begin
      v = {2'h0, c.offset[13:8]};
    end else if (a == pogdr_pkg::OFS_AMP_GAIN) begin
      v = {6'h00, c.amp_gain};
    end else if (a == pogdr_pkg::OFS_RAMP_GAIN) begin
      v = c.ramp_gain;
    end else if (a == pogdr_pkg::OFS_DUMMY) begin
      v = c.dummy;
    end else if (a == pogdr_pkg::OFS_DBL_BLACK) begin
      v[pogdr_pkg::AMP_DOUBLE_BIT] = c.amp_double;
      v[pogdr_pkg::BLACK_EN_BIT] = c.black_en;
    end
    return v;
  endfunction

  // the link clock stops between frames, so chip select clears the frame state
  assign clr = reset | spi_cs_n;
  assign full = {sh_q, spi_sdi};
  assign rd_addr = {sh_q[5:0], spi_sdi};

  always_ff @(posedge spi_clk or posedge clr) begin
    if (clr) begin
      cnt_q <= 5'h00;
      sh_q <= 15'h0000;
    end else begin
      if (cnt_q != pogdr_pkg::SPI_FRAME_END) begin
        cnt_q <= cnt_q + 5'h01;
      end
      sh_q <= {sh_q[13:0], spi_sdi};
    end
  end

  always_ff @(posedge spi_clk or posedge clr) begin
    if (clr) begin
      spi_sdo <= 1'b0;
      rd_sh_q <= 7'h00;
    end else if (cnt_q == pogdr_pkg::SPI_ADDR_LAST && !sh_q[6]) begin
      {spi_sdo, rd_sh_q} <= read_mux(rd_addr, cfg);
    end else if (cnt_q > pogdr_pkg::SPI_ADDR_LAST && cnt_q < pogdr_pkg::SPI_FRAME_LAST) begin
      {spi_sdo, rd_sh_q} <= {rd_sh_q, 1'b0};
    end else begin
      spi_sdo <= 1'b0;
    end
  end

  // word is held until the next write, the toggle marks it as new
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      wr_word <= '0;
      wr_toggle <= 1'b0;
    end else if (!spi_cs_n && cnt_q == pogdr_pkg::SPI_FRAME_LAST && full[15]) begin
      wr_word <= full[14:0];
      wr_toggle <= ~wr_toggle;
    end
  end
endmodule // pogdr_cfg_port

// ===== core/pogdr_top.sv
// pixel conditioning: dark offset, gain settings, black columns and dummy rows
`timescale 1ns/1ps
module pogdr_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  input wire logic transfer_pulse,
  input wire logic exposure_dual,
  input wire pogdr_pkg::pogdr_pix_in_t pix_in,
  output pogdr_pkg::pogdr_pix_out_t pix_out_q,
  output logic row_addr_hold_q,
  output logic [1:0] column_amp_gain_select_q,
  output logic column_amp_double_q,
  output logic [7:0] converter_ramp_gain_q,
  output logic [5:0] column_gain_x10_q,
  output logic black_ref_enable_q,
  output logic integration_sync_select_q,
  output logic [11:0] dark_level_q
);
  pogdr_pkg::pogdr_cfg_t cfg;
  pogdr_pkg::pogdr_wr_t wr_word;
  logic wr_toggle;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic wr_evt;
  logic [13:0] offset_q;
  logic [7:0] dummy_row_count_q;
  logic xfer_q;
  logic xfer_evt;
  logic line_in_q;
  logic row_rise;
  logic row_fall;
  pogdr_pkg::pogdr_state_t state_q;
  pogdr_pkg::pogdr_state_t state_d;
  logic [7:0] pending_q;
  logic [7:0] pending_d;
  logic suppress;
  logic signed [15:0] offset_ext;
  logic signed [15:0] dark_sum;
  logic signed [15:0] pix_sum;
  logic is_black_col;

  // clamps a signed sum into the output code range
  function automatic logic [11:0] sat_code(input logic signed [15:0] v);
    logic [11:0] r;
    r = v[11:0];
    if (v < 16'sh0000) begin
      r = 12'h000;
    end else if (v > $signed({4'h0, pogdr_pkg::CODE_MAX})) begin
      r = pogdr_pkg::CODE_MAX;
    end
    return r;
  endfunction

  function automatic logic [5:0] gain_x10(input logic [1:0] sel, input logic dbl);
    logic [5:0] g;
    case (sel)
      2'h0: g = pogdr_pkg::GAIN_X10_0;
      2'h1: g = pogdr_pkg::GAIN_X10_1;
      2'h2: g = pogdr_pkg::GAIN_X10_2;
      default: g = pogdr_pkg::GAIN_X10_3;
    endcase
    if (dbl) begin
      g = {g[4:0], 1'b0};
    end
    return g;
  endfunction

  assign cfg.inte_sync = integration_sync_select_q;
  assign cfg.offset = offset_q;
  assign cfg.amp_gain = column_amp_gain_select_q;
  assign cfg.ramp_gain = converter_ramp_gain_q;
  assign cfg.dummy = dummy_row_count_q;
  assign cfg.amp_double = column_amp_double_q;
  assign cfg.black_en = black_ref_enable_q;

  pogdr_cfg_port u_cfg_port (
    .spi_clk(spi_clk),
    .reset(reset),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .cfg(cfg),
    .wr_word(wr_word),
    .wr_toggle(wr_toggle)
  );

  // write toggle crosses by two flops; the word itself is held stable meanwhile
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= wr_toggle;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign wr_evt = tog_s2_q ^ tog_s3_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      offset_q <= pogdr_pkg::RST_OFFSET; // RL3
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_OFFSET_LO) begin
      offset_q[7:0] <= wr_word.data; // RL3
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_OFFSET_HI) begin
      offset_q[13:8] <= wr_word.data[5:0]; // RL3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      column_amp_gain_select_q <= pogdr_pkg::RST_AMP_GAIN; // RL4
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_AMP_GAIN) begin
      column_amp_gain_select_q <= wr_word.data[1:0]; // RL4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      converter_ramp_gain_q <= pogdr_pkg::RST_RAMP_GAIN; // RL6
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_RAMP_GAIN) begin
      converter_ramp_gain_q <= wr_word.data; // RL6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dummy_row_count_q <= pogdr_pkg::RST_DUMMY; // RL11
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_DUMMY) begin
      dummy_row_count_q <= wr_word.data;
    end
  end

  // the sync bit only informs the sequencer; insertion follows the count alone
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      integration_sync_select_q <= pogdr_pkg::RST_INTE_SYNC;
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_INTE_SYNC) begin
      integration_sync_select_q <= wr_word.data[pogdr_pkg::INTE_SYNC_BIT]; // RL12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      column_amp_double_q <= pogdr_pkg::RST_AMP_DOUBLE;
      black_ref_enable_q <= pogdr_pkg::RST_BLACK_EN; // RL7
    end else if (wr_evt && wr_word.addr == pogdr_pkg::OFS_DBL_BLACK) begin
      column_amp_double_q <= wr_word.data[pogdr_pkg::AMP_DOUBLE_BIT]; // RL5
      black_ref_enable_q <= wr_word.data[pogdr_pkg::BLACK_EN_BIT]; // RL7
    end
  end

  // effective column gain in tenths, doubling leaves the select untouched
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      column_gain_x10_q <= pogdr_pkg::GAIN_X10_0;
    end else begin
      column_gain_x10_q <= gain_x10(column_amp_gain_select_q, column_amp_double_q); // RL5
    end
  end

  // transfer edge and row edge detection
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      xfer_q <= 1'b0;
      line_in_q <= 1'b0;
    end else begin
      xfer_q <= transfer_pulse;
      line_in_q <= pix_in.line_valid;
    end
  end

  // single exposure reacts to the rising edge, dual exposure to both toggles
  assign xfer_evt = (transfer_pulse & ~xfer_q) |
                    (exposure_dual & ~transfer_pulse & xfer_q); // RL14
  assign row_rise = pix_in.line_valid & ~line_in_q;
  assign row_fall = ~pix_in.line_valid & line_in_q;

  // a row counts from line-valid rise to its fall, however many slots it holds
  always_comb begin
    state_d = state_q;
    pending_d = pending_q;
    case (state_q)
      pogdr_pkg::POGDR_IDLE: begin
        if (xfer_evt && dummy_row_count_q != 8'h00) begin
          pending_d = dummy_row_count_q; // RL8
          state_d = pogdr_pkg::POGDR_ARMED;
        end
      end
      pogdr_pkg::POGDR_ARMED: begin
        if (xfer_evt) begin
          pending_d = dummy_row_count_q; // RL14
        end
        if (row_rise && pending_d != 8'h00) begin
          pending_d = pending_d - 8'h01; // RL13
          state_d = pogdr_pkg::POGDR_DUMMY;
        end else if (pending_d == 8'h00) begin
          state_d = pogdr_pkg::POGDR_IDLE;
        end
      end
      pogdr_pkg::POGDR_DUMMY: begin
        if (xfer_evt) begin
          pending_d = dummy_row_count_q; // RL14
        end
        if (row_fall) begin
          if (pending_d == 8'h00) begin
            state_d = pogdr_pkg::POGDR_IDLE;
          end else begin
            state_d = pogdr_pkg::POGDR_ARMED; // RL13
          end
        end
      end
      default: begin
        state_d = pogdr_pkg::POGDR_IDLE;
        pending_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= pogdr_pkg::POGDR_IDLE; // RL11
      pending_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pending_q <= pending_d;
    end
  end

  // a row is dummy if it starts while armed, or while one is already running
  assign suppress = (state_q == pogdr_pkg::POGDR_DUMMY && !row_fall) ||
                    (state_q == pogdr_pkg::POGDR_ARMED && row_rise &&
                     state_d == pogdr_pkg::POGDR_DUMMY); // RL9

  // tells the row sequencer not to advance, so no image row is lost
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      row_addr_hold_q <= 1'b0;
    end else begin
      row_addr_hold_q <= (state_d != pogdr_pkg::POGDR_IDLE); // RL8
    end
  end

  // offset sign extension and the two sums
  assign offset_ext = {{(16 - pogdr_pkg::OFFSET_W){offset_q[13]}}, offset_q}; // RL1
  assign dark_sum = pogdr_pkg::ADC_FIXED_OFFSET + offset_ext; // RL2
  assign pix_sum = $signed({4'h0, pix_in.code}) + dark_sum; // RL2
  assign is_black_col = black_ref_enable_q && (pix_in.col < pogdr_pkg::BLACK_COLS); // RL7

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dark_level_q <= 12'h000;
    end else begin
      dark_level_q <= sat_code(dark_sum); // RL15
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pix_out_q <= '0;
    end else begin
      pix_out_q.frame_valid <= pix_in.frame_valid;
      pix_out_q.line_valid <= pix_in.line_valid & ~suppress; // RL9
      pix_out_q.pixel_valid <= pix_in.pixel_valid & ~suppress; // RL9
      if (is_black_col) begin
        pix_out_q.code <= sat_code(dark_sum); // RL7
      end else begin
        pix_out_q.code <= sat_code(pix_sum); // RL15
      end
    end
  end
endmodule // pogdr_top

// ===== dv/pogdr_monitor.sv
// concurrent checks on the ports of the pixel conditioning top
`timescale 1ns/1ps
module pogdr_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic transfer_pulse,
  input wire logic exposure_dual,
  input wire pogdr_pkg::pogdr_pix_in_t pix_in,
  input wire pogdr_pkg::pogdr_pix_out_t pix_out_q,
  input wire logic row_addr_hold_q,
  input wire logic [1:0] column_amp_gain_select_q,
  input wire logic column_amp_double_q,
  input wire logic [7:0] converter_ramp_gain_q,
  input wire logic [5:0] column_gain_x10_q,
  input wire logic black_ref_enable_q,
  input wire logic [11:0] dark_level_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic tp_q;
  logic tp_qq;
  logic dual_q;
  always_ff @(posedge sys_clk) begin
    tp_q <= transfer_pulse;
    tp_qq <= tp_q;
    dual_q <= exposure_dual;
  end
  function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[12] ? 12'hfff : s[11:0];
  endfunction
  sequence s_event;
    (tp_q && !tp_qq) || (dual_q && (tp_q != tp_qq));
  endsequence
  sequence s_dark_steady;
    ($past(dark_level_q) == dark_level_q) && ($past(dark_level_q, 2) == dark_level_q);
  endsequence
  property p_hold_cause;
    $rose(row_addr_hold_q) |-> s_event;
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold rose without transfer");
  property p_lv_start;
    $rose(pix_out_q.line_valid) |-> !$past(row_addr_hold_q);
  endproperty
  a_lv_start: assert property (p_lv_start) else $error("line valid in dummy row");
  property p_dv_cause;
    pix_out_q.pixel_valid |-> $past(pix_in.pixel_valid) && pix_out_q.line_valid;
  endproperty
  a_dv_cause: assert property (p_dv_cause) else $error("pixel valid without cause");
  property p_fv_pass;
    pix_out_q.frame_valid == $past(pix_in.frame_valid);
  endproperty
  a_fv_pass: assert property (p_fv_pass) else $error("frame valid not passed");
  property p_gain;
    $stable(column_amp_gain_select_q) && $stable(column_amp_double_q) |->
      column_gain_x10_q == ((6'h0a + {3'h0, column_amp_gain_select_q, 1'b0}) << column_amp_double_q);
  endproperty
  a_gain: assert property (p_gain) else $error("column gain mismatch");
  property p_dark_rst;
    $fell(reset) |=> dark_level_q == 12'h009;
  endproperty
  a_dark_rst: assert property (p_dark_rst) else $error("dark level after reset");
  property p_rst_vals;
    $fell(reset) |-> converter_ramp_gain_q == 8'h20 && column_amp_gain_select_q == 2'h0
      && !column_amp_double_q && !black_ref_enable_q && !row_addr_hold_q;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_code;
    s_dark_steady and (dark_level_q != 12'h000) && (dark_level_q != 12'hfff)
      && !black_ref_enable_q && !$past(black_ref_enable_q)
      |-> pix_out_q.code == sat_add($past(pix_in.code), dark_level_q);
  endproperty
  a_code: assert property (p_code) else $error("pixel code sum wrong");
  property p_black;
    s_dark_steady and black_ref_enable_q && $past(black_ref_enable_q)
      && ($past(pix_in.col) < 11'h010) |-> pix_out_q.code == dark_level_q;
  endproperty
  a_black: assert property (p_black) else $error("black column code wrong");
endmodule // pogdr_monitor

bind pogdr_top pogdr_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
  .transfer_pulse(transfer_pulse), .exposure_dual(exposure_dual), .pix_in(pix_in),
  .pix_out_q(pix_out_q), .row_addr_hold_q(row_addr_hold_q),
  .column_amp_gain_select_q(column_amp_gain_select_q), .column_amp_double_q(column_amp_double_q),
  .converter_ramp_gain_q(converter_ramp_gain_q), .column_gain_x10_q(column_gain_x10_q),
  .black_ref_enable_q(black_ref_enable_q), .dark_level_q(dark_level_q));

// ===== dv/pogdr_rx_model.sv
// receiver model that captures pixels qualified only by the valid strobes
`timescale 1ns/1ps
module pogdr_rx_model (
  input wire logic sys_clk,
  input wire pogdr_pkg::pogdr_pix_out_t pix,
  output int n_rows,
  output int n_pix
);
  logic lv_q = 1'b0;
  int rows_c = 0;
  int pix_c = 0;
  // counters are local so each port has a single driver
  assign n_rows = rows_c;
  assign n_pix = pix_c;
  // no fixed row count is assumed between transfers
  always @(posedge sys_clk) begin
    lv_q <= pix.line_valid;
    if (pix.frame_valid && pix.line_valid && !lv_q) rows_c <= rows_c + 1;
    if (pix.frame_valid && pix.line_valid && pix.pixel_valid) pix_c <= pix_c + 1;
  end
endmodule // pogdr_rx_model

// ===== dv/pogdr_tb.sv
// self-checking bench for the pixel conditioning block
`timescale 1ns/1ps
module pogdr_tb;
  typedef struct packed {
    logic [13:0] ofs;
    logic [11:0] code;
    logic [11:0] dark;
    logic [11:0] out;
  } pogdr_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic spi_clk = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sdi = 1'b0;
  logic spi_sdo;
  logic transfer_pulse = 1'b0;
  logic exposure_dual = 1'b0;
  pogdr_pkg::pogdr_pix_in_t pix_in = '0;
  pogdr_pkg::pogdr_pix_out_t pix_out_q;
  logic hold;
  logic [1:0] amp_sel;
  logic amp_dbl;
  logic [7:0] ramp;
  logic [5:0] gain10;
  logic black_en;
  logic inte_sync;
  logic [11:0] dark;
  logic [7:0] rd;
  logic [11:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int rows;
  int pixs;
  int r0;
  int p0;
  pogdr_row_t tab [7] = '{'{14'h0000, 12'h100, 12'h046, 12'h146},
    '{14'h1fff, 12'h000, 12'hfff, 12'hfff}, '{14'h2000, 12'hfff, 12'h000, 12'h000},
    '{14'h3fc3, 12'h010, 12'h009, 12'h019}, '{14'h3fba, 12'h005, 12'h000, 12'h005},
    '{14'h3fb9, 12'h001, 12'h000, 12'h000}, '{14'h0064, 12'hfa0, 12'h0aa, 12'hfff}};
  logic [6:0] ra [8] = '{7'h29, 7'h64, 7'h65, 7'h66, 7'h67, 7'h76, 7'h79, 7'h10};
  logic [7:0] rv [8] = '{8'h00, 8'hc3, 8'h3f, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};

  pogdr_top dut (.sys_clk(sys_clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .transfer_pulse(transfer_pulse),
    .exposure_dual(exposure_dual), .pix_in(pix_in), .pix_out_q(pix_out_q),
    .row_addr_hold_q(hold), .column_amp_gain_select_q(amp_sel), .column_amp_double_q(amp_dbl),
    .converter_ramp_gain_q(ramp), .column_gain_x10_q(gain10), .black_ref_enable_q(black_en),
    .integration_sync_select_q(inte_sync), .dark_level_q(dark));
  pogdr_rx_model rx (.sys_clk(sys_clk), .pix(pix_out_q), .n_rows(rows), .n_pix(pixs));

  always #2 sys_clk = ~sys_clk;

  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // link clock only runs inside a frame; read bits land in rd
  task automatic spi(input logic wr, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {wr, a, d};
    @(negedge sys_clk);
    #1.3 spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      #32;
      rd = {rd[6:0], spi_sdo};
      spi_clk = 1'b1;
      #32;
      spi_clk = 1'b0;
    end
    spi_cs_n = 1'b1;
    repeat (12) @(negedge sys_clk);
  endtask

  // one-pixel row followed by two idle cycles
  task automatic pix(input logic [10:0] c, input logic [11:0] code, output logic [11:0] o);
    @(negedge sys_clk);
    pix_in = '{1'b1, 1'b1, 1'b1, c, code};
    @(negedge sys_clk);
    o = pix_out_q.code;
    pix_in.line_valid = 1'b0;
    pix_in.pixel_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(dark, 12'h009);
    for (int k = 0; k < 7; k++) begin
      spi(1'b1, 7'h64, tab[k].ofs[7:0]);
      spi(1'b1, 7'h65, {2'b00, tab[k].ofs[13:8]});
      spi(1'b0, 7'h65, 8'h00);
      chk(rd, {2'b00, tab[k].ofs[13:8]});
      chk(dark, tab[k].dark);
      pix(11'h020, tab[k].code, q);
      chk(q, tab[k].out);
    end
    for (int g = 0; g < 8; g++) begin
      spi(1'b1, 7'h66, 8'(g % 4));
      spi(1'b1, 7'h79, 8'(g / 4));
      chk(amp_sel, 16'(g % 4));
      chk(amp_dbl, 16'(g / 4));
      chk(gain10, 16'(10 + 2 * (g % 4)) << (g / 4));
    end
    spi(1'b1, 7'h67, 8'hc8);
    chk(ramp, 16'h00c8);
    spi(1'b1, 7'h64, 8'h00);
    spi(1'b1, 7'h65, 8'h00);
    spi(1'b1, 7'h79, 8'h02);
    chk(black_en, 16'h0001);
    pix(11'h00f, 12'h300, q);
    chk(q, 12'h046);
    pix(11'h010, 12'h300, q);
    chk(q, 12'h346);
    spi(1'b1, 7'h79, 8'h00);
    spi(1'b1, 7'h29, 8'h04);
    spi(1'b1, 7'h76, 8'h02);
    chk(inte_sync, 16'h0001);
    r0 = rows;
    p0 = pixs;
    @(negedge sys_clk);
    transfer_pulse = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(hold, 16'h0001);
    repeat (4) pix(11'h020, 12'h100, q);
    chk(16'(rows - r0), 16'h0002);
    chk(16'(pixs - p0), 16'h0002);
    chk(hold, 16'h0000);
    exposure_dual = 1'b1;
    r0 = rows;
    transfer_pulse = 1'b0;
    repeat (3) pix(11'h020, 12'h100, q);
    chk(16'(rows - r0), 16'h0001);
    exposure_dual = 1'b0;
    // inputs idle across reset, outputs take their reset values while it is held
    pix_in = '0;
    reset = 1'b1;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    chk(ramp, 16'h0020);
    chk(gain10, 16'h000a);
    for (int k = 0; k < 8; k++) begin
      spi(1'b0, ra[k], 8'h00);
      chk(rd, rv[k]);
    end
    r0 = rows;
    transfer_pulse = 1'b1;
    repeat (2) pix(11'h020, 12'h100, q);
    chk(16'(rows - r0), 16'h0002);
    chk(hold, 16'h0000);
    summarize();
  end
endmodule // pogdr_tb
